// ==== rtl/pcrb_pad_bank.sv ====
// Implementation choice: the strobed register port.
`timescale 1ns/100ps
`include "pcrb_cfg.svh"

// Behaviour
// - Input level bit 1 reads the Schmitt input, 0 reads the TTL input.
// - Edge rate bit 1 limits the pad edge rate, 0 gives full rate.
// - Sink-only bit 1 lets the pin pull low only; 0 drives both ways.
// - I2C slew bit 6 set applies I2C limiting, ignoring the standard bit.
// - I2C slew bit clear leaves slew to the standard edge rate bit.
// - Bias field 5:4: 00 weak pull-up, 01 double, 10 tenfold, 11 reserved.
// - Trip field 1:0: 00 standard, 01 I2C, 10 SMBus threshold, 11 reserved.
// - Unimplemented bit positions read as zero, except port A drive disable bit 3, which stays fixed at one.
// - Pin value writes go to the output hold; reads return pin levels.
// - Drive disable bit 1 turns the driver off; 0 turns it on.

module pcrb_pad_bank
  import pcrb_pkg::*;
#(
  parameter int PORTS    = `PCRB_PORTS,
  parameter int I2C_PADS = `PCRB_I2C_PADS
)
(
  // Clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          reset,
  // Register port
  input  wire logic [`PCRB_ADDR_W-1:0]       reg_addr,
  input  wire logic [7:0]                    reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [7:0]                    reg_rdata,
  // Pad inputs
  input  wire pcrb_pad_in_t [PORTS-1:0]      pad_in,
  input  wire pcrb_i2c_in_t [I2C_PADS-1:0]   i2c_in,
  // Pad controls
  output pcrb_pad_out_t [PORTS-1:0]          pad_out,
  output pcrb_i2c_out_t [I2C_PADS-1:0]       i2c_out,
  // Selected levels for change detection
  output logic [PORTS-1:0][7:0]              pin_level
);

  // ==========================================================================
  // Fixed tables
  localparam logic [7:0] PIN_MASK [3] = '{`PCRB_PIN_MASK_A, `PCRB_PIN_MASK_B,
                                         `PCRB_PIN_MASK_C};
  localparam logic [7:0] OUT_MASK [3] = '{`PCRB_OUT_MASK_A, `PCRB_OUT_MASK_B,
                                         `PCRB_OUT_MASK_C};
  localparam logic [7:0] DRV_FIX  [3] = '{`PCRB_DRVDIS_FIX_A, 8'h00, 8'h00};
  // I2C pad placement: port index and bit
  localparam int         I2C_PORT [4] = '{1, 1, 2, 2};
  localparam int         I2C_BIT  [4] = '{4, 6, 0, 1};

  // ==========================================================================
  // Registers
  logic [7:0]     hold_r   [3];
  logic [7:0]     drvdis_r [3];
  logic [7:0]     wbias_r  [3];
  logic [7:0]     sink_r   [3];
  logic [7:0]     slew_r   [3];
  logic [7:0]     inlvl_r  [3];
  logic [7:0]     i2c_r    [4];

  pcrb_sel_t      wsel;
  pcrb_sel_t      rsel;
  logic [7:0]     rdata_nxt;

  // Slice outputs
  logic [7:0]     std_level  [3];
  logic [7:0]     std_oe     [3];
  logic [7:0]     std_drive  [3];
  logic [7:0]     std_edge   [3];
  logic [7:0]     std_pull   [3];

  // I2C pad results
  logic           alt_edge   [4];
  logic           alt_pull   [4];
  logic           alt_level  [4];
  pcrb_i2c_out_t  alt_out    [4];

  // Resolved values
  logic [7:0]     eff_edge   [3];
  logic [7:0]     eff_pull   [3];
  logic [7:0]     eff_level  [3];

  // ==========================================================================
  // Address decode
  function automatic pcrb_sel_t decode(input logic [`PCRB_ADDR_W-1:0] a);
    pcrb_sel_t s;
    s = '{PCRB_REG_NONE, 2'h0};
    case (a)
      `PCRB_OFS_PINVAL_A: s = '{PCRB_REG_PINVAL, 2'h0};
      `PCRB_OFS_PINVAL_B: s = '{PCRB_REG_PINVAL, 2'h1};
      `PCRB_OFS_PINVAL_C: s = '{PCRB_REG_PINVAL, 2'h2};
      `PCRB_OFS_DRVDIS_A: s = '{PCRB_REG_DRVDIS, 2'h0};
      `PCRB_OFS_DRVDIS_B: s = '{PCRB_REG_DRVDIS, 2'h1};
      `PCRB_OFS_DRVDIS_C: s = '{PCRB_REG_DRVDIS, 2'h2};
      `PCRB_OFS_HOLD_A:   s = '{PCRB_REG_HOLD, 2'h0};
      `PCRB_OFS_HOLD_B:   s = '{PCRB_REG_HOLD, 2'h1};
      `PCRB_OFS_HOLD_C:   s = '{PCRB_REG_HOLD, 2'h2};
      `PCRB_OFS_I2C_B4:   s = '{PCRB_REG_I2C, 2'h0};
      `PCRB_OFS_I2C_B6:   s = '{PCRB_REG_I2C, 2'h1};
      `PCRB_OFS_I2C_C0:   s = '{PCRB_REG_I2C, 2'h2};
      `PCRB_OFS_I2C_C1:   s = '{PCRB_REG_I2C, 2'h3};
      `PCRB_OFS_WBIAS_A:  s = '{PCRB_REG_WBIAS, 2'h0};
      `PCRB_OFS_WBIAS_B:  s = '{PCRB_REG_WBIAS, 2'h1};
      `PCRB_OFS_WBIAS_C:  s = '{PCRB_REG_WBIAS, 2'h2};
      `PCRB_OFS_SINK_A:   s = '{PCRB_REG_SINK, 2'h0};
      `PCRB_OFS_SINK_B:   s = '{PCRB_REG_SINK, 2'h1};
      `PCRB_OFS_SINK_C:   s = '{PCRB_REG_SINK, 2'h2};
      `PCRB_OFS_SLEW_A:   s = '{PCRB_REG_SLEW, 2'h0};
      `PCRB_OFS_SLEW_B:   s = '{PCRB_REG_SLEW, 2'h1};
      `PCRB_OFS_SLEW_C:   s = '{PCRB_REG_SLEW, 2'h2};
      `PCRB_OFS_INLVL_A:  s = '{PCRB_REG_INLVL, 2'h0};
      `PCRB_OFS_INLVL_B:  s = '{PCRB_REG_INLVL, 2'h1};
      `PCRB_OFS_INLVL_C:  s = '{PCRB_REG_INLVL, 2'h2};
      default:            s = '{PCRB_REG_NONE, 2'h0};
    endcase
    return s;
  endfunction

  // Write hit on one register of a kind for one port
  function automatic logic hit(input pcrb_sel_t s, input pcrb_reg_kind_t k,
                               input int p);
    return reg_wr && (s.kind == k) && (s.idx == 2'(p));
  endfunction

  assign wsel = decode(reg_addr);
  assign rsel = decode(reg_addr);

  // ==========================================================================
  // Output hold, written through either address
  always_ff @(posedge sys_clk)
  begin
    for (int p = 0; p < 3; p++)
    begin
      if (reset)
        hold_r[p] <= `PCRB_RST_HOLD;
      else if (hit(wsel, PCRB_REG_HOLD, p) || hit(wsel, PCRB_REG_PINVAL, p))
        hold_r[p] <= reg_wdata & OUT_MASK[p];
    end
  end

  // ==========================================================================
  // Drive disable; the input-only pin stays fixed at one
  always_ff @(posedge sys_clk)
  begin
    for (int p = 0; p < 3; p++)
    begin
      if (reset)
        drvdis_r[p] <= `PCRB_RST_DRVDIS & (OUT_MASK[p] | DRV_FIX[p]);
      else if (hit(wsel, PCRB_REG_DRVDIS, p))
        drvdis_r[p] <= (reg_wdata & OUT_MASK[p]) | DRV_FIX[p];
    end
  end

  // ==========================================================================
  // Pad configuration
  always_ff @(posedge sys_clk)
  begin
    for (int p = 0; p < 3; p++)
    begin
      if (reset)
        wbias_r[p] <= `PCRB_RST_WBIAS;
      else if (hit(wsel, PCRB_REG_WBIAS, p))
        wbias_r[p] <= reg_wdata & PIN_MASK[p];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    for (int p = 0; p < 3; p++)
    begin
      if (reset)
        sink_r[p] <= `PCRB_RST_SINK;
      else if (hit(wsel, PCRB_REG_SINK, p))
        sink_r[p] <= reg_wdata & OUT_MASK[p];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    for (int p = 0; p < 3; p++)
    begin
      if (reset)
        slew_r[p] <= `PCRB_RST_SLEW & OUT_MASK[p];
      else if (hit(wsel, PCRB_REG_SLEW, p))
        slew_r[p] <= reg_wdata & OUT_MASK[p];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    for (int p = 0; p < 3; p++)
    begin
      if (reset)
        inlvl_r[p] <= `PCRB_RST_INLVL & PIN_MASK[p];
      else if (hit(wsel, PCRB_REG_INLVL, p))
        inlvl_r[p] <= reg_wdata & PIN_MASK[p];
    end
  end

  // ==========================================================================
  // I2C pad control; reserved codes kept as written
  always_ff @(posedge sys_clk)
  begin
    for (int i = 0; i < 4; i++)
    begin
      if (reset)
        i2c_r[i] <= `PCRB_RST_I2C;
      else if (hit(wsel, PCRB_REG_I2C, i))
        i2c_r[i] <= reg_wdata & `PCRB_I2C_MASK;
    end
  end

  // ==========================================================================
  // Per-port pad logic
  for (genvar p = 0; p < 3; p++)
  begin : g_port
    pcrb_port_slice u_slice (
      .hold                 (hold_r[p]),
      .drive_disable        (drvdis_r[p]),
      .sink_only_drive_bit  (sink_r[p]),
      .edge_rate_limit_bit  (slew_r[p]),
      .input_level_bit      (inlvl_r[p]),
      .weak_bias_enable_bit (wbias_r[p]),
      .pin_mask             (PIN_MASK[p]),
      .schmitt_input        (pad_in[p].schmitt_input),
      .ttl_input            (pad_in[p].ttl_input),
      .drive_level          (std_drive[p]),
      .drive_oe             (std_oe[p]),
      .edge_limit           (std_edge[p]),
      .pull_en              (std_pull[p]),
      .level                (std_level[p])
    );
  end

  for (genvar i = 0; i < 4; i++)
  begin : g_i2c
    pcrb_i2c_pad u_i2c (
      .ctrl           (i2c_r[i]),
      .std_edge_limit (std_edge[I2C_PORT[i]][I2C_BIT[i]]),
      .std_pull_en    (std_pull[I2C_PORT[i]][I2C_BIT[i]]),
      .std_level      (std_level[I2C_PORT[i]][I2C_BIT[i]]),
      .alt_in         (i2c_in[i]),
      .edge_limit     (alt_edge[i]),
      .pull_en        (alt_pull[i]),
      .level          (alt_level[i]),
      .i2c_out        (alt_out[i])
    );
  end

  // ==========================================================================
  // I2C pads override the standard pin values
  always_comb
  begin
    for (int p = 0; p < 3; p++)
    begin
      eff_edge[p]  = std_edge[p];
      eff_pull[p]  = std_pull[p];
      eff_level[p] = std_level[p];
    end
    for (int i = 0; i < 4; i++)
    begin
      eff_edge[I2C_PORT[i]][I2C_BIT[i]]  = alt_edge[i];
      eff_pull[I2C_PORT[i]][I2C_BIT[i]]  = alt_pull[i];
      eff_level[I2C_PORT[i]][I2C_BIT[i]] = alt_level[i];
    end
  end

  // ==========================================================================
  // Registered pad outputs; one cycle behind a register write
  always_ff @(posedge sys_clk)
  begin
    for (int p = 0; p < 3; p++)
    begin
      if (reset)
      begin
        pad_out[p] <= '0;
        pin_level[p] <= 8'h00;
      end
      else
      begin
        pad_out[p].drive_level     <= std_drive[p];
        pad_out[p].drive_oe        <= std_oe[p];
        pad_out[p].edge_rate_limit <= eff_edge[p];
        pad_out[p].pull_en         <= eff_pull[p];
        pin_level[p]               <= eff_level[p];
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    for (int i = 0; i < 4; i++)
    begin
      if (reset)
        i2c_out[i] <= '0;
      else
        i2c_out[i] <= alt_out[i];
    end
  end

  // ==========================================================================
  // Read path; pin value reads see live levels, not the hold
  always_comb
  begin
    rdata_nxt = 8'h00;
    unique case (rsel.kind)
      PCRB_REG_PINVAL: rdata_nxt = eff_level[rsel.idx] & PIN_MASK[rsel.idx];
      PCRB_REG_HOLD:   rdata_nxt = hold_r[rsel.idx];
      PCRB_REG_DRVDIS: rdata_nxt = drvdis_r[rsel.idx];
      PCRB_REG_WBIAS:  rdata_nxt = wbias_r[rsel.idx];
      PCRB_REG_SINK:   rdata_nxt = sink_r[rsel.idx];
      PCRB_REG_SLEW:   rdata_nxt = slew_r[rsel.idx];
      PCRB_REG_INLVL:  rdata_nxt = inlvl_r[rsel.idx];
      PCRB_REG_I2C:    rdata_nxt = i2c_r[rsel.idx];
      PCRB_REG_NONE:   rdata_nxt = 8'h00;
    endcase
  end

  // Data only valid in the cycle after the strobe, zero otherwise
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= rdata_nxt;
    else
      reg_rdata <= 8'h00;
  end

endmodule

// ==== rtl/pcrb_cfg.svh ====
`ifndef PCRB_CFG_SVH
`define PCRB_CFG_SVH

// ==========================================================================
// Geometry
`define PCRB_ADDR_W          13
`define PCRB_PORTS           3
`define PCRB_I2C_PADS        4

// ==========================================================================
// Register offsets, pin level / drive / hold
`define PCRB_OFS_PINVAL_A    13'h000c
`define PCRB_OFS_PINVAL_B    13'h000d
`define PCRB_OFS_PINVAL_C    13'h000e
`define PCRB_OFS_DRVDIS_A    13'h0011
`define PCRB_OFS_DRVDIS_B    13'h0013
`define PCRB_OFS_DRVDIS_C    13'h0014
`define PCRB_OFS_HOLD_A      13'h0018
`define PCRB_OFS_HOLD_B      13'h0019
`define PCRB_OFS_HOLD_C      13'h001a

// ==========================================================================
// Register offsets, I2C pad control
`define PCRB_OFS_I2C_B4      13'h010c
`define PCRB_OFS_I2C_B6      13'h010d
`define PCRB_OFS_I2C_C0      13'h010e
`define PCRB_OFS_I2C_C1      13'h010f

// ==========================================================================
// Register offsets, pad configuration
`define PCRB_OFS_WBIAS_A     13'h1f39
`define PCRB_OFS_SINK_A      13'h1f3a
`define PCRB_OFS_SLEW_A      13'h1f3b
`define PCRB_OFS_INLVL_A     13'h1f3c
`define PCRB_OFS_WBIAS_B     13'h1f44
`define PCRB_OFS_SINK_B      13'h1f45
`define PCRB_OFS_SLEW_B      13'h1f46
`define PCRB_OFS_INLVL_B     13'h1f47
`define PCRB_OFS_WBIAS_C     13'h1f4f
`define PCRB_OFS_SINK_C      13'h1f50
`define PCRB_OFS_SLEW_C      13'h1f51
`define PCRB_OFS_INLVL_C     13'h1f52

// ==========================================================================
// Implemented bits per port
`define PCRB_PIN_MASK_A      8'h3f
`define PCRB_PIN_MASK_B      8'hf0
`define PCRB_PIN_MASK_C      8'hff
`define PCRB_OUT_MASK_A      8'h37
`define PCRB_OUT_MASK_B      8'hf0
`define PCRB_OUT_MASK_C      8'hff
`define PCRB_DRVDIS_FIX_A    8'h08
`define PCRB_I2C_MASK        8'h73

// ==========================================================================
// I2C control fields
`define PCRB_I2C_SLEW_BIT    6
`define PCRB_I2C_BIAS_HI     5
`define PCRB_I2C_BIAS_LO     4
`define PCRB_I2C_TRIP_HI     1
`define PCRB_I2C_TRIP_LO     0
`define PCRB_CODE_STD        2'h0
`define PCRB_CODE_ALT1       2'h1
`define PCRB_CODE_ALT2       2'h2

// ==========================================================================
// Reset values
`define PCRB_RST_HOLD        8'h00
`define PCRB_RST_DRVDIS      8'hff
`define PCRB_RST_WBIAS       8'h00
`define PCRB_RST_SINK        8'h00
`define PCRB_RST_SLEW        8'hff
`define PCRB_RST_INLVL       8'hff
`define PCRB_RST_I2C         8'h00

`endif

// ==== rtl/pcrb_pkg.sv ====
package pcrb_pkg;

  // ========================================================================
  // Register kinds
  typedef enum logic [3:0] {
    PCRB_REG_NONE   = 4'h0,
    PCRB_REG_PINVAL = 4'h1,
    PCRB_REG_DRVDIS = 4'h2,
    PCRB_REG_HOLD   = 4'h3,
    PCRB_REG_WBIAS  = 4'h4,
    PCRB_REG_SINK   = 4'h5,
    PCRB_REG_SLEW   = 4'h6,
    PCRB_REG_INLVL  = 4'h7,
    PCRB_REG_I2C    = 4'h8
  } pcrb_reg_kind_t;

  typedef struct packed {
    pcrb_reg_kind_t kind;
    logic [1:0]     idx;
  } pcrb_sel_t;

  // ========================================================================
  // Pad carriers
  typedef struct packed {
    logic [7:0] schmitt_input;
    logic [7:0] ttl_input;
  } pcrb_pad_in_t;

  typedef struct packed {
    logic [7:0] drive_level;
    logic [7:0] drive_oe;
    logic [7:0] edge_rate_limit;
    logic [7:0] pull_en;
  } pcrb_pad_out_t;

  typedef struct packed {
    logic i2c_level;
    logic smbus_level;
  } pcrb_i2c_in_t;

  typedef struct packed {
    logic i2c_slew;
    logic bias_2x;
    logic bias_10x;
    logic trip_i2c;
    logic trip_smbus;
  } pcrb_i2c_out_t;

endpackage

// ==== rtl/pcrb_port_slice.sv ====
`timescale 1ns/100ps
`include "pcrb_cfg.svh"

module pcrb_port_slice
  import pcrb_pkg::*;
(
  // Configuration
  input  wire logic [7:0] hold,
  input  wire logic [7:0] drive_disable,
  input  wire logic [7:0] sink_only_drive_bit,
  input  wire logic [7:0] edge_rate_limit_bit,
  input  wire logic [7:0] input_level_bit,
  input  wire logic [7:0] weak_bias_enable_bit,
  input  wire logic [7:0] pin_mask,
  // Pad side
  input  wire logic [7:0] schmitt_input,
  input  wire logic [7:0] ttl_input,
  output logic      [7:0] drive_level,
  output logic      [7:0] drive_oe,
  output logic      [7:0] edge_limit,
  output logic      [7:0] pull_en,
  output logic      [7:0] level
);

  // ========================================================================
  // Drive
  // Sink-only pins emulate open drain by enabling the driver for lows only
  assign drive_level = hold & ~sink_only_drive_bit & pin_mask;
  assign drive_oe    = ~drive_disable & (~sink_only_drive_bit | ~hold) & pin_mask;
  assign edge_limit  = edge_rate_limit_bit & pin_mask;
  // Pull-up is dropped while the drive disable bit is clear, register kept
  assign pull_en     = weak_bias_enable_bit & drive_disable & pin_mask;

  // ========================================================================
  // Input level
  assign level = ((input_level_bit & schmitt_input) |
                  (~input_level_bit & ttl_input)) & pin_mask;

endmodule

// ==== rtl/pcrb_i2c_pad.sv ====
`timescale 1ns/100ps
`include "pcrb_cfg.svh"

module pcrb_i2c_pad
  import pcrb_pkg::*;
(
  // Control
  input  wire logic [7:0]    ctrl,
  // Standard pad behaviour
  input  wire logic          std_edge_limit,
  input  wire logic          std_pull_en,
  input  wire logic          std_level,
  input  wire pcrb_i2c_in_t  alt_in,
  // Resolved behaviour
  output logic               edge_limit,
  output logic               pull_en,
  output logic               level,
  output pcrb_i2c_out_t      i2c_out
);

  logic [1:0] bias;
  logic [1:0] trip;
  logic       slew;

  assign slew = ctrl[`PCRB_I2C_SLEW_BIT];
  assign bias = ctrl[`PCRB_I2C_BIAS_HI:`PCRB_I2C_BIAS_LO];
  assign trip = ctrl[`PCRB_I2C_TRIP_HI:`PCRB_I2C_TRIP_LO];

  // ========================================================================
  // Slew
  // I2C limiting replaces the standard limiter outright
  assign edge_limit         = slew ? 1'b0 : std_edge_limit;
  assign i2c_out.i2c_slew   = slew;

  // ========================================================================
  // Pull-up strength; reserved code falls back to the weak pull-up
  assign i2c_out.bias_2x    = (bias == `PCRB_CODE_ALT1);
  assign i2c_out.bias_10x   = (bias == `PCRB_CODE_ALT2);
  assign pull_en            = (i2c_out.bias_2x | i2c_out.bias_10x) ? 1'b1 : std_pull_en;

  // ========================================================================
  // Input threshold; reserved code falls back to the standard level
  assign i2c_out.trip_i2c   = (trip == `PCRB_CODE_ALT1);
  assign i2c_out.trip_smbus = (trip == `PCRB_CODE_ALT2);
  always_comb
  begin
    if (i2c_out.trip_i2c)
      level = alt_in.i2c_level;
    else if (i2c_out.trip_smbus)
      level = alt_in.smbus_level;
    else
      level = std_level;
  end

endmodule

// ==== testbench/pcrb_pin_model.sv ====
`timescale 1ns/100ps
module pcrb_pin_model
  import pcrb_pkg::*;
(
  // Pad side of the bank
  input  wire pcrb_pad_out_t [2:0] pad_out,
  output pcrb_pad_in_t [2:0]       pad_in,
  output pcrb_i2c_in_t [3:0]       i2c_in,
  // Far-side drive when released
  input  wire logic [2:0][7:0]     ext,
  input  wire logic [2:0][7:0]     skew
);
  // ========
  // Pin levels
  logic [2:0][7:0] pin;
  always_comb
  begin
    for (int p = 0; p < 3; p++)
    begin
      // Released pin: pull-up wins, else whatever the board drives
      pin[p] = (pad_out[p].drive_oe & pad_out[p].drive_level)
             | (~pad_out[p].drive_oe & (pad_out[p].pull_en | ext[p]));
      // Buffers may disagree near threshold
      pad_in[p] = {pin[p], pin[p] ^ skew[p]};
    end
    i2c_in[0] = {~pin[1][4], pin[1][4] ^ skew[1][4]};
    i2c_in[1] = {~pin[1][6], pin[1][6] ^ skew[1][6]};
    i2c_in[2] = {~pin[2][0], pin[2][0] ^ skew[2][0]};
    i2c_in[3] = {~pin[2][1], pin[2][1] ^ skew[2][1]};
  end
endmodule

// ==== testbench/pcrb_pad_bank_chk.sv ====
`timescale 1ns/100ps
module pcrb_pad_bank_chk
  import pcrb_pkg::*;
#(
  parameter int PORTS    = 3,
  parameter int I2C_PADS = 4
)
(
  // Clock, reset, register port
  input wire logic                         sys_clk,
  input wire logic                         reset,
  input wire logic [12:0]                  reg_addr,
  input wire logic                         reg_rd,
  input wire logic [7:0]                   reg_rdata,
  // Pads
  input wire pcrb_pad_in_t [PORTS-1:0]     pad_in,
  input wire pcrb_pad_out_t [PORTS-1:0]    pad_out,
  input wire pcrb_i2c_out_t [I2C_PADS-1:0] i2c_out,
  input wire logic [PORTS-1:0][7:0]        pin_level
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic bias_both;
  logic trip_both;
  logic slew_clash;
  logic pull_miss;
  logic c_same;
  always_comb
  begin
    bias_both = 1'b0;
    trip_both = 1'b0;
    for (int k = 0; k < I2C_PADS; k++)
    begin
      bias_both = bias_both | (i2c_out[k].bias_2x & i2c_out[k].bias_10x);
      trip_both = trip_both | (i2c_out[k].trip_i2c & i2c_out[k].trip_smbus);
    end
  end
  // ========
  // I2C pads sit on B4, B6, C0, C1
  assign slew_clash = (i2c_out[0].i2c_slew & pad_out[1].edge_rate_limit[4])
                    | (i2c_out[1].i2c_slew & pad_out[1].edge_rate_limit[6])
                    | (i2c_out[2].i2c_slew & pad_out[2].edge_rate_limit[0])
                    | (i2c_out[3].i2c_slew & pad_out[2].edge_rate_limit[1]);
  assign pull_miss = ((i2c_out[0].bias_2x | i2c_out[0].bias_10x) & ~pad_out[1].pull_en[4])
                   | ((i2c_out[1].bias_2x | i2c_out[1].bias_10x) & ~pad_out[1].pull_en[6])
                   | ((i2c_out[2].bias_2x | i2c_out[2].bias_10x) & ~pad_out[2].pull_en[0])
                   | ((i2c_out[3].bias_2x | i2c_out[3].bias_10x) & ~pad_out[2].pull_en[1]);
  assign c_same = pad_in[2].schmitt_input == pad_in[2].ttl_input;
  // ========
  // Assertions
  a_unmapped_zero: assert property (reg_rd && reg_addr == 13'h0010 |=> reg_rdata == 8'h00)
    else $error("unmapped read gave data");
  a_pin_a_unimpl: assert property (reg_rd && reg_addr == 13'h000c |=>
    reg_rdata[7:6] == 2'h0)
    else $error("missing port A pins read nonzero");
  a_no_drive_unimpl: assert property ((pad_out[0].drive_oe & 8'hc8) == 8'h00 &&
    pad_out[1].drive_oe[3:0] == 4'h0)
    else $error("driver on for a missing pin");
  a_bias_exclusive: assert property (!bias_both)
    else $error("two bias strengths at once");
  a_trip_exclusive: assert property (!trip_both)
    else $error("two trip levels at once");
  a_slew_override: assert property (!slew_clash)
    else $error("standard slew limit left on");
  a_bias_pull: assert property (!pull_miss)
    else $error("strong bias without pull-up");
  a_read_level: assert property (reg_rd && reg_addr == 13'h000e && c_same |=>
    reg_rdata[7:2] == $past(pad_in[2].schmitt_input[7:2]))
    else $error("pin value read wrong level");
  a_level_track: assert property ($past(c_same) && !$past(reset) |->
    pin_level[2][7:2] == $past(pad_in[2].schmitt_input[7:2]))
    else $error("selected level wrong");
  c_unmapped: cover property (reg_rd && reg_addr == 13'h0010);
  c_i2c_slew: cover property (i2c_out[0].i2c_slew);
  c_bias_10x: cover property (i2c_out[3].bias_10x);
endmodule
bind pcrb_pad_bank pcrb_pad_bank_chk #(.PORTS(PORTS), .I2C_PADS(I2C_PADS)) i_chk (
  .sys_clk(sys_clk),
  .reset(reset),
  .reg_addr(reg_addr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .pad_in(pad_in),
  .pad_out(pad_out),
  .i2c_out(i2c_out),
  .pin_level(pin_level)
);

// ==== testbench/test_pcrb_pad_bank.sv ====
`timescale 1ns/100ps
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin bad_count++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module test_pcrb_pad_bank
  import pcrb_pkg::*;
;
  logic                 sys_clk, reset, reg_wr, reg_rd;
  logic [12:0]          reg_addr;
  logic [7:0]           reg_wdata, reg_rdata, rd_v;
  pcrb_pad_in_t [2:0]   pad_in;
  pcrb_i2c_in_t [3:0]   i2c_in;
  pcrb_pad_out_t [2:0]  pad_out;
  pcrb_i2c_out_t [3:0]  i2c_out;
  logic [2:0][7:0]      pin_level, ext, skew;
  logic [7:0]           sh [22];
  int                   bad_count, compares, k;
  // ========
  // Map: drive disable, hold, I2C, weak bias, sink-only, slew, input level
  localparam logic [12:0] ADR [22] = '{13'h0011, 13'h0013, 13'h0014, 13'h0018, 13'h0019,
    13'h001a, 13'h010c, 13'h010d, 13'h010e, 13'h010f, 13'h1f39, 13'h1f44, 13'h1f4f,
    13'h1f3a, 13'h1f45, 13'h1f50, 13'h1f3b, 13'h1f46, 13'h1f51, 13'h1f3c, 13'h1f47, 13'h1f52};
  localparam logic [7:0] MSK [22] = '{8'h37, 8'hf0, 8'hff, 8'h37, 8'hf0, 8'hff, 8'h73, 8'h73,
    8'h73, 8'h73, 8'h3f, 8'hf0, 8'hff, 8'h37, 8'hf0,
    8'hff, 8'h37, 8'hf0, 8'hff, 8'h3f, 8'hf0, 8'hff};
  localparam logic [7:0] RST [22] = '{8'h3f, 8'hf0, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h37, 8'hf0, 8'hff, 8'h3f, 8'hf0, 8'hff};
  localparam logic [7:0] OM [3] = '{8'h37, 8'hf0, 8'hff};
  localparam logic [7:0] PM [3] = '{8'h3f, 8'hf0, 8'hff};
  localparam int IP [4] = '{1, 1, 2, 2};
  localparam int IB [4] = '{4, 6, 0, 1};
  pcrb_pad_bank i_dut (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pad_in(pad_in), .i2c_in(i2c_in), .pad_out(pad_out), .i2c_out(i2c_out),
    .pin_level(pin_level));
  pcrb_pin_model i_pins (.pad_out(pad_out), .pad_in(pad_in), .i2c_in(i2c_in), .ext(ext),
    .skew(skew));
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // ========
  // Bus tasks
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [12:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    v = reg_rdata;
  endtask
  task automatic wreg(input int n, input logic [7:0] d);
    wr(ADR[n], d);
    sh[n] = (d & MSK[n]) | ((n == 0) ? 8'h08 : 8'h00);
  endtask
  // ========
  // Expectations
  function automatic pcrb_pad_out_t exp_out(input int p);
    pcrb_pad_out_t o;
    o.drive_level = sh[3+p] & ~sh[13+p];
    o.drive_oe = ~sh[p] & (~sh[13+p] | ~sh[3+p]) & OM[p];
    o.edge_rate_limit = sh[16+p];
    o.pull_en = sh[10+p] & sh[p];
    for (int i = 0; i < 4; i++)
    begin
      if (IP[i] == p && sh[6+i][6])
        o.edge_rate_limit[IB[i]] = 1'b0;
      if (IP[i] == p && (sh[6+i][5:4] == 2'h1 || sh[6+i][5:4] == 2'h2))
        o.pull_en[IB[i]] = 1'b1;
    end
    return o;
  endfunction
  function automatic logic [7:0] exp_lvl(input int p);
    logic [7:0] v;
    v = (sh[19+p] & pad_in[p].schmitt_input) | (~sh[19+p] & pad_in[p].ttl_input);
    for (int i = 0; i < 4; i++)
    begin
      if (IP[i] == p && sh[6+i][1:0] == 2'h1)
        v[IB[i]] = i2c_in[i].i2c_level;
      if (IP[i] == p && sh[6+i][1:0] == 2'h2)
        v[IB[i]] = i2c_in[i].smbus_level;
    end
    return v & PM[p];
  endfunction
  function automatic pcrb_i2c_out_t exp_i2c(input int i);
    return {sh[6+i][6], sh[6+i][5:4] == 2'h1, sh[6+i][5:4] == 2'h2, sh[6+i][1:0] == 2'h1,
      sh[6+i][1:0] == 2'h2};
  endfunction
  task automatic check_all();
    logic [7:0] v;
    repeat (3) @(posedge sys_clk);
    for (int p = 0; p < 3; p++)
    begin
      rd(13'h000c + 13'(p), v);
      `CHK("pin_value", exp_lvl(p), v)
      `CHK("pin_level", exp_lvl(p), pin_level[p])
      `CHK("pad_out", exp_out(p), pad_out[p])
    end
    for (int i = 0; i < 4; i++)
      `CHK("i2c_out", exp_i2c(i), i2c_out[i])
  endtask
  task automatic final_report();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Hang guard
  initial
  begin
    repeat (50000) @(posedge sys_clk);
    bad_count++;
    final_report();
  end
  initial
  begin
    {reset, reg_wr, reg_rd, reg_addr, reg_wdata, ext, skew} = '0;
    reset = 1'b1;
    bad_count = 0;
    compares = 0;
    void'($urandom(25));
    repeat (6) @(posedge sys_clk);
    reset <= 1'b0;
    for (k = 0; k < 22; k++)
    begin
      sh[k] = RST[k];
      rd(ADR[k], rd_v);
      `CHK("reset_value", RST[k], rd_v)
    end
    wr(13'h0010, 8'hff);
    rd(13'h0010, rd_v);
    `CHK("unmapped", 8'h00, rd_v)
    // All ones: missing bits read zero, except port A drive disable bit 3, which reads one
    for (k = 0; k < 22; k++)
    begin
      wreg(k, 8'hff);
      rd(ADR[k], rd_v);
      `CHK("masked_readback", sh[k], rd_v)
    end
    check_all();
    // Every slew, bias and trip code, reserved ones included
    for (k = 0; k < 16; k++)
    begin
      for (int i = 0; i < 4; i++)
        wreg(6 + i, {1'b0, k[0] ^ k[2], k[1:0], 2'h0, k[3:2]});
      check_all();
    end
    repeat (60)
    begin
      k = $urandom_range(21);
      wreg(k, 8'($urandom));
      if ($urandom_range(1) == 1)
      begin
        rd_v = 8'($urandom);
        wr(13'h000c + 13'(k % 3), rd_v);
        sh[3 + k % 3] = rd_v & OM[k % 3];
      end
      ext <= 24'($urandom);
      skew <= ($urandom_range(2) == 0) ? 24'h0 : 24'($urandom);
      rd(ADR[k], rd_v);
      `CHK("readback", sh[k], rd_v)
      check_all();
    end
    final_report();
  end
endmodule
